// >>> core/qr_valley_pkg.sv
package qr_valley_pkg;

    // gate sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_SUPPRESS = 4'b0001,
        ST_WAIT     = 4'b0010,
        ST_BLANK    = 4'b0100,
        ST_ON       = 4'b1000
    } gate_state_type;

    // comparator results from the analog front end
    typedef struct packed {
        logic line_above_upper;
        logic line_above_lower;
        logic fb_above_upcount_stop;
        logic fb_above_downcount;
        logic fb_above_counter_reset;
        logic zcd_below_zero_crossing;
        logic zcd_below_suppression_select;
        logic current_above_feedback;
    } sense_type;

endpackage : qr_valley_pkg

// >>> core/qr_valley_regs.svh
`ifndef QR_VALLEY_REGS_SVH
`define QR_VALLEY_REGS_SVH

// clock rate
`define QRV_CLK_MHZ           200
`define QRV_CLK_KHZ           200000

// register byte offsets
`define QRV_CTRL_OFFSET       12'h000
`define QRV_STATUS_OFFSET     12'h004
`define QRV_COUNT_OFFSET      12'h008

// control fields and reset value
`define QRV_CTRL_EN_BIT       0
`define QRV_CTRL_RESET        32'h0000_0001

// status fields
`define QRV_STAT_GATE_BIT     0
`define QRV_STAT_HIGH_BIT     1
`define QRV_STAT_SOFT_BIT     2
`define QRV_STAT_STATE_LSB    4

// count register fields
`define QRV_COUNT_TARGET_LSB  0
`define QRV_COUNT_VALLEY_LSB  8

// valley bounds per line
`define QRV_LOW_MIN           4'h1
`define QRV_LOW_MAX           4'h8
`define QRV_HIGH_MIN          4'h3
`define QRV_HIGH_MAX          4'ha

// times in their own units
`define QRV_EVAL_MS           48
`define QRV_SOFT_MS           3
`define QRV_SOFT_RS_US        25
`define QRV_MIN_FREQ_KHZ      20
`define QRV_LEB_NS            300
`define QRV_ON_MAX_NS         30000
`define QRV_RS_SHORT_NS       2500
`define QRV_RS_LONG_NS        25000
`define QRV_LINE_BLANK_NS     10000

// cycle counts: least times round up, longest times round down
`define QRV_EVAL_CYCLES       (`QRV_EVAL_MS * `QRV_CLK_KHZ)
`define QRV_SOFT_CYCLES       (`QRV_SOFT_MS * `QRV_CLK_KHZ)
`define QRV_SOFT_RS_CYCLES    (`QRV_SOFT_RS_US * `QRV_CLK_MHZ)
`define QRV_OFF_MAX_CYCLES    (`QRV_CLK_KHZ / `QRV_MIN_FREQ_KHZ)
`define QRV_LEB_CYCLES        ((`QRV_LEB_NS * `QRV_CLK_MHZ + 999) / 1000)
`define QRV_ON_MAX_CYCLES     ((`QRV_ON_MAX_NS * `QRV_CLK_MHZ) / 1000)
`define QRV_RS_SHORT_CYCLES   ((`QRV_RS_SHORT_NS * `QRV_CLK_MHZ + 999) / 1000)
`define QRV_RS_LONG_CYCLES    ((`QRV_RS_LONG_NS * `QRV_CLK_MHZ + 999) / 1000)
`define QRV_LINE_BLANK_CYCLES ((`QRV_LINE_BLANK_NS * `QRV_CLK_MHZ + 999) / 1000)

`endif

// >>> core/quasi_resonant_valley_switch_control.sv
// Summary of operation
// - minimum valley count is 1 on low line, 3 on high line.
// - line decision changes only with hysteresis and after a blanking time.
// - feedback checked against three thresholds each 48 ms period; target updated.
// - feedback always below upcount-stop: target increments, stopping at 8 or 10.
// - above upcount-stop but never downcount: target unchanged.
// - above downcount but never counter-reset: target decrements, stopping at 1 or 3.
// - feedback above counter-reset loads target with the line minimum at once.
// - target clamped to 1..8 or 3..10 at each period end; steps leaving the range ignored.
// - target starts at its minimum after reset.
// - after turn-off each falling zero crossing adds one to the valley counter.
// - valley counter stops at the line's upper bound.
// - valley counter cleared whenever the gate goes high.
// - suppression time long when zero-crossing pin low, short when high.
// - gate held low for the whole suppression time after turn-off.
// - after suppression, gate turns on when valley count equals target.
// - gate turns on after maximum off time regardless of counters.
// - switch-off comparator turns the gate off.
// - switch-off comparator ignored for leading-edge blanking after turn-on.
// - gate turned off once on longer than maximum on time.
// - first 3 ms of soft start use a fixed 25 us suppression time.
//
// The APB register port and the register addresses were chosen for this implementation.
`include "qr_valley_regs.svh"

module quasi_resonant_valley_switch_control
    import qr_valley_pkg::*;
#(
    parameter int unsigned EVAL_CYCLES       = `QRV_EVAL_CYCLES,
    parameter int unsigned SOFT_CYCLES       = `QRV_SOFT_CYCLES,
    parameter int unsigned SOFT_RS_CYCLES    = `QRV_SOFT_RS_CYCLES,
    parameter int unsigned OFF_MAX_CYCLES    = `QRV_OFF_MAX_CYCLES,
    parameter int unsigned LEB_CYCLES        = `QRV_LEB_CYCLES,
    parameter int unsigned ON_MAX_CYCLES     = `QRV_ON_MAX_CYCLES,
    parameter int unsigned RS_SHORT_CYCLES   = `QRV_RS_SHORT_CYCLES,
    parameter int unsigned RS_LONG_CYCLES    = `QRV_RS_LONG_CYCLES,
    parameter int unsigned LINE_BLANK_CYCLES = `QRV_LINE_BLANK_CYCLES,
    parameter int unsigned TIMER_W           = 16,
    parameter int unsigned EVAL_W            = 24,
    parameter int unsigned SOFT_W            = 20,
    parameter int unsigned LINE_W            = 12
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire sense_type   sense_in,
    output logic             gate_drive,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);

    // synchronised comparators and edge detect
    sense_type             sense_meta;
    sense_type             sense;
    logic                  zc_prev;
    logic                  zc_fall;

    // line decision and valley bounds
    logic                  high_line;
    logic [LINE_W-1:0]     line_cnt;
    logic                  line_differs;
    logic [3:0]            lo_bound;
    logic [3:0]            hi_bound;

    // target valley path
    logic [3:0]            target;
    logic [3:0]            next_target;
    logic [3:0]            base;
    logic [EVAL_W-1:0]     eval_cnt;
    logic                  eval_end;
    logic                  up_seen;
    logic                  down_seen;
    logic                  reset_seen;

    // valley counter and gate sequencer
    logic [3:0]            valley;
    gate_state_type        state;
    logic [TIMER_W-1:0]    off_timer;
    logic [TIMER_W-1:0]    on_timer;
    logic [TIMER_W-1:0]    rs_len;
    logic                  turn_on;
    logic                  turn_off;

    // soft start and bus
    logic [SOFT_W-1:0]     soft_cnt;
    logic                  soft_active;
    logic                  enable;
    logic                  apb_write;

    // control register reset image
    localparam logic [31:0] CTRL_RESET = `QRV_CTRL_RESET;

    // two-flop synchroniser for all comparator results
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sense_meta <= '0;
            sense      <= '0;
        end else begin
            sense_meta <= sense_in;
            sense      <= sense_meta;
        end
    end

    // falling zero-crossing edge detect on the synchronised level
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            zc_prev <= 1'b0;
        end else begin
            zc_prev <= sense.zcd_below_zero_crossing;
        end
    end

    assign zc_fall = sense.zcd_below_zero_crossing & ~zc_prev;

    // line decision: upper threshold to go high, lower to go low, then blanking
    assign line_differs = high_line ? ~sense.line_above_lower
                                    : sense.line_above_upper;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            high_line <= 1'b0;
            line_cnt  <= '0;
        end else if (!line_differs) begin
            line_cnt <= '0;
        end else if (line_cnt >= LINE_W'(LINE_BLANK_CYCLES - 1)) begin
            high_line <= ~high_line;
            line_cnt  <= '0;
        end else begin
            line_cnt <= line_cnt + 1'b1;
        end
    end

    // valley bounds per line
    assign lo_bound = high_line ? `QRV_HIGH_MIN : `QRV_LOW_MIN;
    assign hi_bound = high_line ? `QRV_HIGH_MAX : `QRV_LOW_MAX;

    // evaluation period timer
    assign eval_end = (eval_cnt == EVAL_W'(EVAL_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            eval_cnt <= '0;
        end else if (eval_end) begin
            eval_cnt <= '0;
        end else begin
            eval_cnt <= eval_cnt + 1'b1;
        end
    end

    // per-period latches of threshold crossings, cleared at period end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            up_seen    <= 1'b0;
            down_seen  <= 1'b0;
            reset_seen <= 1'b0;
        end else if (eval_end) begin
            up_seen    <= 1'b0;
            down_seen  <= 1'b0;
            reset_seen <= 1'b0;
        end else begin
            up_seen    <= up_seen | sense.fb_above_upcount_stop;
            down_seen  <= down_seen | sense.fb_above_downcount;
            reset_seen <= reset_seen | sense.fb_above_counter_reset;
        end
    end

    // target valley update; a crossing in the final cycle counts for that period
    always_comb begin
        // clamp into the current line range first
        base = target;
        if (target < lo_bound) begin
            base = lo_bound;
        end else if (target > hi_bound) begin
            base = hi_bound;
        end
        // period-end step, highest crossing wins
        next_target = target;
        if (eval_end) begin
            if (reset_seen | sense.fb_above_counter_reset) begin
                next_target = lo_bound;
            end else if (down_seen | sense.fb_above_downcount) begin
                next_target = (base > lo_bound) ? base - 4'h1 : base;
            end else if (up_seen | sense.fb_above_upcount_stop) begin
                next_target = base;
            end else begin
                next_target = (base < hi_bound) ? base + 4'h1 : base;
            end
        end
        // counter-reset also acts at once
        if (sense.fb_above_counter_reset) begin
            next_target = lo_bound;
        end
    end

    // target valley register, starts at the low-line minimum
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            target <= `QRV_LOW_MIN;
        end else begin
            target <= next_target;
        end
    end

    // valley counter: cleared at turn-on, counts crossings while off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            valley <= '0;
        end else if (turn_on) begin
            valley <= '0;
        end else if (!gate_drive && zc_fall && valley < hi_bound) begin
            valley <= valley + 4'h1;
        end
    end

    // soft-start window timer, restarted while switching is disabled
    assign soft_active = (soft_cnt < SOFT_W'(SOFT_CYCLES));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            soft_cnt <= '0;
        end else if (!enable) begin
            soft_cnt <= '0;
        end else if (soft_active) begin
            // stops once the window has passed
            soft_cnt <= soft_cnt + 1'b1;
        end
    end

    // suppression length, chosen live from the pin level
    always_comb begin
        if (soft_active) begin
            rs_len = TIMER_W'(SOFT_RS_CYCLES);
        end else if (sense.zcd_below_suppression_select) begin
            rs_len = TIMER_W'(RS_LONG_CYCLES);
        end else begin
            rs_len = TIMER_W'(RS_SHORT_CYCLES);
        end
    end

    // turn-on and turn-off decisions
    always_comb begin
        turn_on  = 1'b0;
        turn_off = 1'b0;
        unique case (state)
            ST_SUPPRESS: begin
                turn_on = 1'b0;
            end
            ST_WAIT: begin
                turn_on = enable && ((valley == target)
                    || (off_timer >= TIMER_W'(OFF_MAX_CYCLES - 1)));
            end
            ST_BLANK: begin
                turn_off = (on_timer >= TIMER_W'(ON_MAX_CYCLES - 1));
            end
            ST_ON: begin
                turn_off = sense.current_above_feedback
                    || (on_timer >= TIMER_W'(ON_MAX_CYCLES - 1));
            end
        endcase
    end

    // gate sequencer with off and on timers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state      <= ST_SUPPRESS;
            gate_drive <= 1'b0;
            off_timer  <= '0;
            on_timer   <= '0;
        end else if (!enable) begin
            // disabled: gate low, timers restart
            state      <= ST_SUPPRESS;
            gate_drive <= 1'b0;
            off_timer  <= '0;
            on_timer   <= '0;
        end else begin
            unique case (state)
                ST_SUPPRESS: begin
                    // gate held low, off time counted
                    if (off_timer != {TIMER_W{1'b1}}) begin
                        off_timer <= off_timer + 1'b1;
                    end
                    if (off_timer >= rs_len - 1'b1) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // valley match or off-time limit
                    if (off_timer != {TIMER_W{1'b1}}) begin
                        off_timer <= off_timer + 1'b1;
                    end
                    if (turn_on) begin
                        state      <= ST_BLANK;
                        gate_drive <= 1'b1;
                        on_timer   <= '0;
                    end
                end
                ST_BLANK: begin
                    // only the on-time limit may turn the gate off during blanking
                    on_timer <= on_timer + 1'b1;
                    if (turn_off) begin
                        state      <= ST_SUPPRESS;
                        gate_drive <= 1'b0;
                        off_timer  <= '0;
                    end else if (on_timer >= TIMER_W'(LEB_CYCLES - 1)) begin
                        state <= ST_ON;
                    end
                end
                ST_ON: begin
                    // comparator or on-time limit ends it
                    if (on_timer != {TIMER_W{1'b1}}) begin
                        on_timer <= on_timer + 1'b1;
                    end
                    if (turn_off) begin
                        state      <= ST_SUPPRESS;
                        gate_drive <= 1'b0;
                        off_timer  <= '0;
                    end
                end
            endcase
        end
    end

    // apb: answer registered in the setup cycle, ready in the first access cycle
    assign apb_write = psel & penable & pready & pwrite;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable <= CTRL_RESET[`QRV_CTRL_EN_BIT];
        end else if (apb_write && paddr == `QRV_CTRL_OFFSET) begin
            enable <= pwdata[`QRV_CTRL_EN_BIT];
        end
    end

    // read data, ready and error
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            // captured in setup, shown in the access cycle
            if (psel && !penable) begin
                unique case (paddr)
                    `QRV_CTRL_OFFSET: begin
                        prdata[`QRV_CTRL_EN_BIT] <= enable;
                    end
                    `QRV_STATUS_OFFSET: begin
                        prdata[`QRV_STAT_GATE_BIT]                <= gate_drive;
                        prdata[`QRV_STAT_HIGH_BIT]                <= high_line;
                        prdata[`QRV_STAT_SOFT_BIT]                <= soft_active;
                        prdata[`QRV_STAT_STATE_LSB +: 4]          <= state;
                    end
                    `QRV_COUNT_OFFSET: begin
                        prdata[`QRV_COUNT_TARGET_LSB +: 4]        <= target;
                        prdata[`QRV_COUNT_VALLEY_LSB +: 4]        <= valley;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : quasi_resonant_valley_switch_control

// >>> verif/qrv_power_stage.sv
module qrv_power_stage #(
    parameter int RING_DELAY  = 15,
    parameter int RING_PERIOD = 16
) (
    input  wire logic ref_clk,
    input  wire logic gate_drive,
    input  wire logic ring_on,
    input  wire logic zcd_low,
    input  wire logic spike_on,
    input  wire logic [31:0] on_len,
    output logic      current_high,
    output logic      zcd_below,
    output logic      zcd_sel_below
);
    timeunit 1ns;
    timeprecision 1ps;

    int t_on = 0;
    int t_off = 0;
    int ph;

    // time since the last gate edge
    always @(posedge ref_clk) begin
        t_on <= gate_drive ? t_on + 1 : 0;
        t_off <= gate_drive ? 0 : t_off + 1;
    end

    // shunt ramp, optional turn-on spike, zero means no trip
    assign current_high = gate_drive
        && ((spike_on && t_on < 3) || (on_len != 0 && t_on >= on_len));
    // damped ringing: twelve valleys, then flat above threshold
    assign ph = t_off - RING_DELAY;
    assign zcd_below = !gate_drive && ring_on && ph >= 0 && ph < 12 * RING_PERIOD
        && (ph % RING_PERIOD) < RING_PERIOD / 2;
    // winding level against the suppression select threshold
    assign zcd_sel_below = zcd_low;
endmodule : qrv_power_stage

// >>> verif/qrv_properties.sv
`include "qr_valley_regs.svh"

module qrv_properties
    import qr_valley_pkg::*;
#(
    parameter int unsigned LEB_CYCLES      = 60,
    parameter int unsigned ON_MAX_CYCLES   = 6000,
    parameter int unsigned OFF_MAX_CYCLES  = 10000,
    parameter int unsigned RS_SHORT_CYCLES = 500
) (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire sense_type   sense_in,
    input wire logic        gate_drive,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned on_cnt;
    int unsigned off_cnt;
    logic        done;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // samples spent high and low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            on_cnt  <= 0;
            off_cnt <= 0;
        end else begin
            on_cnt  <= gate_drive ? on_cnt + 1 : 0;
            off_cnt <= gate_drive ? 0 : off_cnt + 1;
        end
    end

    // completed bus access
    assign done = psel && penable && pready;

    leb_min_a: assert property ($fell(gate_drive) |-> on_cnt >= LEB_CYCLES)
        else $error("gate on shorter than blanking");
    on_max_a: assert property (gate_drive |-> on_cnt <= ON_MAX_CYCLES)
        else $error("gate on past maximum");
    off_max_a: assert property (!gate_drive |-> off_cnt <= OFF_MAX_CYCLES)
        else $error("gate off past maximum");
    supp_min_a: assert property ($rose(gate_drive) |-> off_cnt >= RS_SHORT_CYCLES)
        else $error("gate on inside suppression");
    turn_off_a: assert property (gate_drive && on_cnt >= LEB_CYCLES
        && sense_in.current_above_feedback |-> ##[1:4] !gate_drive)
        else $error("current trip ignored");
    answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle");
    bad_addr_a: assert property (done && paddr > `QRV_COUNT_OFFSET |-> pslverr && prdata == 0)
        else $error("unmapped access accepted");
    count_rng_a: assert property (done && !pwrite && paddr == `QRV_COUNT_OFFSET
        |-> prdata[3:0] inside {[4'h1:4'ha]} && prdata[11:8] <= 4'ha)
        else $error("counter out of range");
endmodule : qrv_properties

bind quasi_resonant_valley_switch_control qrv_properties #(
    .LEB_CYCLES(LEB_CYCLES), .ON_MAX_CYCLES(ON_MAX_CYCLES),
    .OFF_MAX_CYCLES(OFF_MAX_CYCLES), .RS_SHORT_CYCLES(RS_SHORT_CYCLES)
) qrv_properties_i (
    .ref_clk(ref_clk), .resetn(resetn), .sense_in(sense_in), .gate_drive(gate_drive),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr)
);

// >>> verif/test_quasi_resonant_valley_switch_control.sv
`include "qr_valley_regs.svh"

module test_quasi_resonant_valley_switch_control
    import qr_valley_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int EVAL = 64;
    localparam int ON_MAX = 100;
    localparam int OFF_MAX = 200;
    localparam int RS_L = 30;
    localparam int SOFT_RS = 20;

    logic        ref_clk = 1'h0, resetn = 1'h0, line_up = 1'h0, line_lo = 1'h0;
    logic        ring_on = 1'h1, zcd_low = 1'h0, spike_on = 1'h0, cur, zc, zsel;
    logic [2:0]  fb = 3'h0;
    int          on_len = 20, fail_count = 0, n_tests = 0, cycles = 0;
    sense_type   sense_in;
    logic        gate_drive, pready, pslverr, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;

    // comparator bits, msb first
    assign sense_in = {line_up, line_lo, fb, zc, zsel, cur};

    quasi_resonant_valley_switch_control #(
        .EVAL_CYCLES(EVAL), .SOFT_CYCLES(50), .SOFT_RS_CYCLES(SOFT_RS), .OFF_MAX_CYCLES(OFF_MAX),
        .LEB_CYCLES(6), .ON_MAX_CYCLES(ON_MAX), .RS_SHORT_CYCLES(10),
        .RS_LONG_CYCLES(RS_L), .LINE_BLANK_CYCLES(8)
    ) quasi_resonant_valley_switch_control_i (
        .ref_clk(ref_clk), .resetn(resetn), .sense_in(sense_in), .gate_drive(gate_drive),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );
    qrv_power_stage qrv_power_stage_i (
        .ref_clk(ref_clk), .gate_drive(gate_drive), .ring_on(ring_on), .zcd_low(zcd_low),
        .spike_on(spike_on), .on_len(on_len), .current_high(cur), .zcd_below(zc),
        .zcd_sel_below(zsel)
    );

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_in(input int v, input int lo, input int hi);
        n_tests++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, v, lo, hi);
        end
    endtask : check_in

    // one transfer, request held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
        apb(1'h0, a, 32'h0, d, e);
    endtask : rd

    // one full on and off phase, sampled mid-cycle
    task automatic measure(output int on_t, output int off_t);
        on_t = 0;
        off_t = 0;
        do @(negedge ref_clk); while (gate_drive !== 1'h0);
        do @(negedge ref_clk); while (gate_drive !== 1'h1);
        while (gate_drive === 1'h1) begin
            on_t++;
            @(negedge ref_clk);
        end
        while (gate_drive === 1'h0) begin
            off_t++;
            @(negedge ref_clk);
        end
    endtask : measure

    // m is {zcd low, spike, ringing}; settle st cycles, then time two cycles, checking the second
    task automatic gate_case(input logic [2:0] f, m, input int ol, st, a, b, c, d);
        int on_t;
        int off_t;
        @(posedge ref_clk);
        fb <= f;
        {zcd_low, spike_on, ring_on} <= m;
        on_len <= ol;
        repeat (st) @(posedge ref_clk);
        repeat (2) measure(on_t, off_t);
        check_in(on_t, a, b);
        check_in(off_t, c, d);
    endtask : gate_case

    task automatic line_step(input logic up, lo, input int n, input logic exp);
        logic [31:0] d;
        logic        e;
        @(posedge ref_clk);
        line_up <= up;
        line_lo <= lo;
        repeat (n) @(posedge ref_clk);
        rd(`QRV_STATUS_OFFSET, d, e);
        check(d[`QRV_STAT_HIGH_BIT], exp);
    endtask : line_step

    task automatic test_reset;
        logic [31:0] d;
        logic        e;
        rd(`QRV_COUNT_OFFSET, d, e);
        check(d[3:0], 4'h1);
        rd(`QRV_STATUS_OFFSET, d, e);
        check(d[`QRV_STAT_HIGH_BIT], 1'h0);
        apb(1'h1, `QRV_CTRL_OFFSET, `QRV_CTRL_RESET, d, e);
        rd(`QRV_CTRL_OFFSET, d, e);
        check(d, `QRV_CTRL_RESET);
        rd(12'h010, d, e);
        check(d, 32'h0);
        check(e, 1'h1);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_gate;
        gate_case(3'h7, 3'h1, 20, 0, 20, 25, 15, 22);
        gate_case(3'h7, 3'h5, 20, 0, 20, 25, RS_L, RS_L + 6);
        gate_case(3'h7, 3'h3, 20, 0, 20, 25, 15, 22);
        gate_case(3'h7, 3'h1, 0, 0, ON_MAX - 3, ON_MAX + 3, 15, 22);
        gate_case(3'h7, 3'h0, 20, 0, 20, 25, OFF_MAX - 3, OFF_MAX + 3);
        gate_case(3'h0, 3'h1, 20, 12 * EVAL, 20, 25, 126, 136);
        $display("test_gate done");
    endtask : test_gate

    task automatic test_counter;
        logic [2:0]  fbs[10] = '{3'h7, 3'h0, 3'h4, 3'h6, 3'h4, 3'h4, 3'h0, 3'h6, 3'h0, 3'h7};
        int          per[10] = '{2, 12, 3, 12, 3, 2, 12, 12, 12, 0};
        logic [3:0]  exp[10] = '{4'h1, 4'h8, 4'h8, 4'h1, 4'h1, 4'h3, 4'ha, 4'h3, 4'ha, 4'h3};
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 10; i++) begin
            if (i == 5) begin
                line_step(1'h1, 1'h1, 2, 1'h0);
                line_step(1'h0, 1'h1, 20, 1'h0);
                line_step(1'h1, 1'h1, 20, 1'h1);
            end
            @(posedge ref_clk);
            fb <= fbs[i];
            repeat (per[i] * EVAL + 6) @(posedge ref_clk);
            rd(`QRV_COUNT_OFFSET, d, e);
            check(d[3:0], exp[i]);
        end
        line_step(1'h0, 1'h1, 20, 1'h1);
        line_step(1'h0, 1'h0, 20, 1'h0);
        $display("test_counter done");
    endtask : test_counter

    // disable mid-on, re-enable: soft start must use the fixed suppression
    task automatic test_soft;
        logic [31:0] d;
        logic        e;
        int          off_t;
        @(posedge ref_clk);
        zcd_low <= 1'h1;
        do @(negedge ref_clk); while (gate_drive !== 1'h0);
        do @(negedge ref_clk); while (gate_drive !== 1'h1);
        repeat (6) @(posedge ref_clk);
        apb(1'h1, `QRV_CTRL_OFFSET, 32'h0, d, e);
        apb(1'h1, `QRV_CTRL_OFFSET, `QRV_CTRL_RESET, d, e);
        off_t = 0;
        while (gate_drive !== 1'h1) begin
            off_t++;
            @(negedge ref_clk);
        end
        check_in(off_t, SOFT_RS - 2, SOFT_RS + 4);
        $display("test_soft done");
    endtask : test_soft

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'h1;
        test_reset();
        test_gate();
        test_counter();
        test_soft();
        test_done();
    end
endmodule : test_quasi_resonant_valley_switch_control
